// File: rtl/dispenser_discrete_io_control.sv
`include "dio_defines.svh"
module dispenser_discrete_io_control (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Link to controller
  dio_if.dev io,
  // User interface
  input wire logic ui_clear_i,
  output logic regulate_o,
  output logic warn_o,
  output logic busy_o,
  output logic [4:0] program_o
);
  // ----------------------------------------------------------------------
  // Input synchronisers and width filters
  // ----------------------------------------------------------------------
  logic [`DIO_NUM_IN-1:0] raw;
  logic [`DIO_NUM_IN-1:0] s1_q, s2_q, s1_d, s2_d;
  logic [`DIO_NUM_IN-1:0] flt_q, flt_d, prv_q, prv_d;
  logic [`DIO_CNT_W-1:0] cnt_q [`DIO_NUM_IN];
  logic [`DIO_CNT_W-1:0] cnt_d [`DIO_NUM_IN];

  // Bit order: estop, clear, vtrig, contact, step
  assign raw = {io.estop, io.clear, io.vtrig, io.contact, io.prog_step};

  // Minimum width per input
  function automatic logic [`DIO_CNT_W-1:0] min_w(input int idx);
    if (idx == 2 || idx == 1)
      return `DIO_CNT_W'(`DIO_TRIG_CYC);
    return `DIO_CNT_W'(`DIO_SLOW_CYC);
  endfunction

  // Stability counter per input
  genvar g;
  generate
    for (g = 0; g < `DIO_NUM_IN; g++) begin : g_flt
      always_comb begin
        s1_d[g] = raw[g];
        s2_d[g] = s1_q[g];
        flt_d[g] = flt_q[g];
        cnt_d[g] = cnt_q[g];
        prv_d[g] = flt_q[g];
        if (s2_q[g] == flt_q[g]) begin
          cnt_d[g] = '0;
        end else if (cnt_q[g] >= min_w(g) - `DIO_CNT_W'(2)) begin
          flt_d[g] = s2_q[g]; // see R15
          cnt_d[g] = '0;
        end else begin
          cnt_d[g] = cnt_q[g] + `DIO_CNT_W'(1);
        end
      end
      always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          flt_q[g] <= 1'b0;
          prv_q[g] <= 1'b0;
          cnt_q[g] <= '0;
        end else begin
          s1_q[g] <= s1_d[g];
          s2_q[g] <= s2_d[g];
          flt_q[g] <= flt_d[g];
          prv_q[g] <= prv_d[g];
          cnt_q[g] <= cnt_d[g];
        end
      end
    end
  endgenerate

  // Qualified levels and edges
  logic estop_lv, clr_rise, trig_rise, step_rise;
  assign estop_lv = flt_q[4];
  assign clr_rise = flt_q[3] & ~prv_q[3];
  assign trig_rise = (flt_q[2] & ~prv_q[2]) | (flt_q[1] & ~prv_q[1]);
  assign step_rise = flt_q[0] & ~prv_q[0];

  // ----------------------------------------------------------------------
  // Program selector
  // ----------------------------------------------------------------------
  logic [`DIO_PROG_W-1:0] prog_q, prog_d;
  always_comb begin
    prog_d = prog_q;
    if (step_rise) begin // see R4
      if (prog_q == `DIO_PROG_LAST)
        prog_d = `DIO_PROG_FIRST; // see R5
      else
        prog_d = prog_q + `DIO_PROG_W'(1);
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i)
      prog_q <= `DIO_PROG_FIRST;
    else
      prog_q <= prog_d;
  end

  // ----------------------------------------------------------------------
  // Dispense and alarm sequencer
  // ----------------------------------------------------------------------
  dio_pkg::disp_state_t st_q, st_d;
  logic [`DIO_CNT_W-1:0] dcnt_q, dcnt_d;
  logic alarm_q, alarm_d, eoc_n_q, eoc_n_d, reg_q, reg_d;
  logic busy_q, busy_d;
  always_comb begin
    st_d = st_q;
    dcnt_d = dcnt_q;
    unique case (st_q)
      dio_pkg::ST_IDLE: begin
        if (estop_lv) begin
          st_d = dio_pkg::ST_ALRM; // see R7
        end else if (trig_rise) begin
          st_d = dio_pkg::ST_DISP; // see R1, R2, R3
          dcnt_d = '0;
        end
      end
      dio_pkg::ST_DISP: begin
        if (estop_lv) begin
          st_d = dio_pkg::ST_ALRM;
        end else if (dcnt_q == `DIO_DISP_CYC - `DIO_CNT_W'(1)) begin
          st_d = dio_pkg::ST_IDLE;
        end else begin
          dcnt_d = dcnt_q + `DIO_CNT_W'(1);
        end
      end
      dio_pkg::ST_ALRM: begin
        // Held while stop high; triggers ignored
        if (!estop_lv && (ui_clear_i || clr_rise))
          st_d = dio_pkg::ST_IDLE; // see R6, R8, R9, R11, R12
      end
      default: st_d = dio_pkg::ST_IDLE;
    endcase
    alarm_d = (st_d == dio_pkg::ST_ALRM); // see R10
    eoc_n_d = (st_d != dio_pkg::ST_DISP); // see R13
    reg_d = (st_d != dio_pkg::ST_ALRM); // see R7
    busy_d = (st_d == dio_pkg::ST_DISP); // see R13
  end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_q <= dio_pkg::ST_IDLE;
      dcnt_q <= '0;
      alarm_q <= 1'b0;
      eoc_n_q <= 1'b1;
      reg_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      dcnt_q <= dcnt_d;
      alarm_q <= alarm_d;
      eoc_n_q <= eoc_n_d;
      reg_q <= reg_d;
      busy_q <= busy_d;
    end
  end

  // Outputs
  assign io.alarm = alarm_q;
  assign io.eoc_n = eoc_n_q;
  assign regulate_o = reg_q;
  assign warn_o = alarm_q;
  assign busy_o = busy_q;
  assign program_o = prog_q;
endmodule // dispenser_discrete_io_control

// File: rtl/dio_defines.svh
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH
// Overview of operation
// R1 - Voltage trigger edge starts cycle, width 10ms
// R2 - Held trigger gives one cycle only
// R3 - Contact closure starts cycle like trigger
// R4 - Program-step edge advances program, width 100ms
// R5 - Program 1..16, wraps 16 to 1
// R6 - Emergency stop held while input high
// R7 - Stop halts regulation, raises alarm, warns
// R8 - Stop persists until UI or clear
// R9 - Alarm-clear input clears alarm or stop
// R10 - Alarm output high exactly in alarm
// R11 - No dispense starts during alarm
// R12 - Alarm held until UI or clear
// R13 - End-of-cycle low while dispensing
// R14 - Controller clears only after stop released
// R15 - Inputs synchronised and width-filtered

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DIO_CLK_HZ 10000000
`define DIO_TRIG_MIN_US 10000
`define DIO_SLOW_MIN_US 100000
`define DIO_TRIG_CYC ((`DIO_CLK_HZ / 1000000) * `DIO_TRIG_MIN_US)
`define DIO_SLOW_CYC ((`DIO_CLK_HZ / 1000000) * `DIO_SLOW_MIN_US)
`define DIO_CNT_W 20
`define DIO_DISP_CYC 20'h186A0
// ----------------------------------------------------------------------
// Program numbering
// ----------------------------------------------------------------------
`define DIO_PROG_FIRST 5'h01
`define DIO_PROG_LAST 5'h10
`define DIO_PROG_W 5
`define DIO_NUM_IN 5
`endif

// File: rtl/dio_pkg.sv
package dio_pkg;
  // Dispenser sequencing states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_DISP = 3'h2,
    ST_ALRM = 3'h4
  } disp_state_t;
endpackage

// File: rtl/dio_if.sv
interface dio_if;
  logic estop;
  logic clear;
  logic vtrig;
  logic contact;
  logic prog_step;
  logic alarm;
  logic eoc_n;
  // Dispenser end
  modport dev (input estop, clear, vtrig, contact, prog_step,
               output alarm, eoc_n);
  // Controller end
  modport ctl (output estop, clear, vtrig, contact, prog_step,
               input alarm, eoc_n);
endinterface

// File: rtl/dispenser_controller_end.sv
`include "dio_defines.svh"
module dispenser_controller_end (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // User requests (one-cycle pulses; estop_i is a level)
  input wire logic trig_req_i,
  input wire logic contact_req_i,
  input wire logic step_req_i,
  input wire logic clear_req_i,
  input wire logic estop_i,
  // Link to dispenser
  dio_if.ctl io,
  // Status back to user
  output logic alarm_o,
  output logic dispensing_o,
  output logic busy_o
);
  // ----------------------------------------------------------------------
  // Pulse stretchers
  // ----------------------------------------------------------------------
  localparam int N = 4;
  logic [N-1:0] req;
  logic [N-1:0] on_q, on_d;
  logic [`DIO_CNT_W-1:0] c_q [N];
  logic [`DIO_CNT_W-1:0] c_d [N];
  logic alarm_q, disp_q, estop_q;

  // Order: trig, contact, step, clear
  assign req = {trig_req_i, contact_req_i, step_req_i,
                clear_req_i & ~estop_q & ~estop_i}; // see R14

  // Hold time for each line with margin of four cycles
  function automatic logic [`DIO_CNT_W-1:0] hold_w(input int idx);
    if (idx >= 2)
      return `DIO_CNT_W'(`DIO_TRIG_CYC + 4); // see R1
    return `DIO_CNT_W'(`DIO_SLOW_CYC + 4); // see R4, R9
  endfunction

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_str
      always_comb begin
        on_d[g] = on_q[g];
        c_d[g] = c_q[g];
        if (!on_q[g] && req[g]) begin
          on_d[g] = 1'b1;
          c_d[g] = '0;
        end else if (on_q[g]) begin
          if (c_q[g] == hold_w(g) - `DIO_CNT_W'(1))
            on_d[g] = 1'b0;
          else
            c_d[g] = c_q[g] + `DIO_CNT_W'(1);
        end
      end
      always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
          on_q[g] <= 1'b0;
          c_q[g] <= '0;
        end else begin
          on_q[g] <= on_d[g];
          c_q[g] <= c_d[g];
        end
      end
    end
  endgenerate

  // Level stop and status sampling
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      estop_q <= 1'b0;
      alarm_q <= 1'b0;
      disp_q <= 1'b0;
    end else begin
      estop_q <= estop_i; // see R6
      alarm_q <= io.alarm;
      disp_q <= ~io.eoc_n;
    end
  end

  assign io.vtrig = on_q[3];
  assign io.contact = on_q[2];
  assign io.prog_step = on_q[1];
  assign io.clear = on_q[0];
  assign io.estop = estop_q;
  assign alarm_o = alarm_q;
  assign dispensing_o = disp_q;
  assign busy_o = |on_q;
endmodule // dispenser_controller_end

// File: testbench/dio_link_checker.sv
`include "dio_defines.svh"
module dio_link_checker (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Link signals
  input wire logic estop,
  input wire logic clear,
  input wire logic vtrig,
  input wire logic contact,
  input wire logic alarm,
  input wire logic eoc_n,
  // User interface clear
  input wire logic ui_clear
);
  logic [20:0] est_q, est_d, clr_q, clr_d, trg_q, trg_d, low_q, low_d;

  // Saturating run lengths of link levels
  always_comb begin
    est_d = estop ? est_q + {20'h0, ~&est_q} : 21'h0;
    clr_d = clear ? clr_q + {20'h0, ~&clr_q} : 21'h0;
    trg_d = (vtrig | contact) ? trg_q + {20'h0, ~&trg_q} : 21'h0;
    low_d = !eoc_n ? low_q + {20'h0, ~&low_q} : 21'h0;
  end
  always_ff @(posedge ref_clk_i) begin
    {est_q, clr_q, trg_q, low_q} <= sys_rst_i ? 84'h0
                                   : {est_d, clr_d, trg_d, low_d};
  end

  // ----
  // Link properties
  // ----
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_no_disp_alarm:
    assert property (alarm && $past(alarm) |-> eoc_n)
    else $error("dispense active in alarm");
  chk_stop_holds:
    assert property (alarm && estop |=> alarm)
    else $error("alarm dropped with stop held");
  chk_stop_cause:
    assert property ($rose(alarm) |-> est_q >= `DIO_SLOW_CYC)
    else $error("alarm without qualified stop");
  chk_leave_stop:
    assert property ($fell(alarm) |-> !estop)
    else $error("alarm left with stop high");
  chk_clear_width:
    assert property ($fell(alarm) |->
                     clr_q >= `DIO_SLOW_CYC || $past(ui_clear))
    else $error("alarm left without qualified clear");
  chk_trig_width:
    assert property ($fell(eoc_n) |-> trg_q >= `DIO_TRIG_CYC)
    else $error("dispense without qualified trigger");
  chk_disp_max:
    assert property (!eoc_n |-> low_q < `DIO_DISP_CYC)
    else $error("dispense too long");
  chk_disp_len:
    assert property ($rose(eoc_n) && !alarm |-> low_q == `DIO_DISP_CYC)
    else $error("dispense length wrong");
endmodule // dio_link_checker

// File: testbench/dispenser_discrete_io_control_test.sv
`include "dio_defines.svh"
module dispenser_discrete_io_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TW = `DIO_TRIG_CYC + 20;
  localparam int SW = `DIO_SLOW_CYC + 20;
  localparam int DW = `DIO_DISP_CYC;
  logic ref_clk_i, sys_rst_i, trig, contact, step, clr, estop, ui_clear;
  logic regulate, warn, dbusy, alarm_s, disp_s, cbusy;
  logic [4:0] prog_num;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  dio_if link();
  dispenser_discrete_io_control dispenser_discrete_io_control_inst (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .io(link),
    .ui_clear_i(ui_clear), .regulate_o(regulate), .warn_o(warn),
    .busy_o(dbusy), .program_o(prog_num));
  dispenser_controller_end dispenser_controller_end_inst (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .trig_req_i(trig),
    .contact_req_i(contact), .step_req_i(step), .clear_req_i(clr),
    .estop_i(estop), .io(link), .alarm_o(alarm_s),
    .dispensing_o(disp_s), .busy_o(cbusy));
  dio_link_checker dio_link_checker_inst (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .estop(link.estop),
    .clear(link.clear), .vtrig(link.vtrig), .contact(link.contact),
    .alarm(link.alarm), .eoc_n(link.eoc_n), .ui_clear(ui_clear));

  // Verdict and end of run
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Compare one value
  task automatic check(input string n, input logic [4:0] e,
                       input logic [4:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // One-cycle request pulse on the controller side
  task automatic req(input int k);
    @(negedge ref_clk_i);
    case (k)
      0: trig = 1'b1;
      1: contact = 1'b1;
      2: step = 1'b1;
      default: clr = 1'b1;
    endcase
    @(negedge ref_clk_i);
    {trig, contact, step, clr} = 4'h0;
  endtask

  // Clock and hang limit
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 9000000) begin
      miscompares++;
      summarize();
    end
  end

  // ----
  // Scenarios
  // ----
  initial begin
    {trig, contact, step, clr, estop, ui_clear} = 6'h00;
    sys_rst_i = 1'b1;
    repeat (5) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    @(negedge ref_clk_i);
    check("eoc_n", 5'h01, link.eoc_n);
    check("program", 5'h01, prog_num);
    check("alarm", 5'h00, link.alarm);
    for (int k = 0; k < 2; k++) begin
      req(k);
      check("cbusy", 5'h01, cbusy);
      repeat (TW) @(negedge ref_clk_i);
      check("eoc_n", 5'h00, link.eoc_n);
      check("busy", 5'h01, dbusy);
      check("dispensing", 5'h01, disp_s);
      check("cbusy", 5'h00, cbusy);
      repeat (DW) @(negedge ref_clk_i);
      check("eoc_n", 5'h01, link.eoc_n);
    end
    req(2);
    repeat (SW) @(negedge ref_clk_i);
    check("program", 5'h02, prog_num);
    estop = 1'b1;
    repeat (SW) @(negedge ref_clk_i);
    check("alarm", 5'h01, link.alarm);
    check("warn", 5'h01, warn);
    check("regulate", 5'h00, regulate);
    check("alarm_o", 5'h01, alarm_s);
    req(0);
    repeat (TW) @(negedge ref_clk_i);
    check("eoc_n", 5'h01, link.eoc_n);
    req(3);
    repeat (SW) @(negedge ref_clk_i);
    check("alarm", 5'h01, link.alarm);
    estop = 1'b0;
    repeat (SW) @(negedge ref_clk_i);
    check("alarm", 5'h01, link.alarm);
    req(3);
    repeat (SW) @(negedge ref_clk_i);
    check("alarm", 5'h00, link.alarm);
    check("regulate", 5'h01, regulate);
    estop = 1'b1;
    repeat (SW) @(negedge ref_clk_i);
    check("alarm", 5'h01, link.alarm);
    estop = 1'b0;
    repeat (SW) @(negedge ref_clk_i);
    ui_clear = 1'b1;
    @(negedge ref_clk_i);
    ui_clear = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    check("alarm", 5'h00, link.alarm);
    summarize();
  end
endmodule // dispenser_discrete_io_control_test
